// ==== sar_conversion_control.sv ====
// Control logic of a 16-bit successive-approximation converter.
// Assumes the analog comparator and range detectors are sampled on clk_i
// and that host pins arrive asynchronously.
`default_nettype none

module sar_conversion_control
	import sar_pkg::*;
#(
	parameter logic [15:0] GAP_CYCLES = 16'(WARP_GAP_CYC)
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              convert_start_n_i,
	input  wire logic              coding_select_i,
	input  wire logic              sleep_request_i,
	input  wire logic              cs_n_i,
	input  wire logic              rd_n_i,
	input  wire logic              comp_i,
	input  wire logic              over_range_i,
	input  wire logic              under_range_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   track_o,
	output logic                   hold_o,
	output logic                   busy_o,
	output logic      [15:0]       dac_trial_o,
	output logic                   low_power_o,
	output logic                   power_down_o,
	output logic      [15:0]       data_o,
	output logic                   data_oe_n_o
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Acquisition count per mode, loaded as cycles minus one.
	function automatic logic [3:0] acq_count(input mode_type m);
		case (m)
			MODE_WARP:    acq_count = 4'(ACQ_WARP_CYC - 1); // R6
			MODE_IMPULSE: acq_count = 4'(ACQ_IMPULSE_CYC - 1);
			default:      acq_count = 4'(ACQ_NORMAL_CYC - 1); // R8
		endcase
	endfunction

	// Turns a straight binary code into the selected output coding.
	function automatic logic [15:0] fmt_code(input logic [15:0] raw,
	                                         input logic        straight);
		if (straight) begin // R11
			fmt_code = raw; // R12
		end else begin
			fmt_code = {~raw[15], raw[14:0]}; // R13
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [PIN_N-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	logic             cnv_fall;
	logic             rd_rise;

	// A pin level is accepted once the second and third stages agree.
	always_comb begin
		pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
	end

	// Three-stage synchroniser plus accepted level.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q  <= PIN_RST;
			s2_q  <= PIN_RST;
			s3_q  <= PIN_RST;
			pin_q <= PIN_RST;
		end else begin
			s1_q  <= {rd_n_i, cs_n_i, sleep_request_i, coding_select_i,
			          convert_start_n_i};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= pin_d;
		end
	end

	// Edges of the accepted levels.
	assign cnv_fall = pin_q[PIN_CNV] && !pin_d[PIN_CNV]; // R1
	assign rd_rise  = !pin_q[PIN_RD] && pin_d[PIN_RD] && !pin_q[PIN_CS];

	////////////////////////////////////////////////////////////////////////
	// Result FIFO.

	result_word_type        word_q, word_d;
	result_word_type        head;
	logic                   push;
	logic                   pop;
	logic                   fifo_ready;
	logic                   fifo_valid;
	logic [4:0]             fifo_level;

	// Finished results queue here until software or the pins take them.
	sar_fifo #(
		.WIDTH($bits(result_word_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.in_valid_i (push),
		.in_ready_o (fifo_ready),
		.in_data_i  (word_d),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o (head),
		.level_o    (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Conversion state machine.

	state_type   state_q, state_d;
	mode_type    mode_q, mode_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [15:0] sar_q, sar_d;
	logic [3:0]  bit_q, bit_d;
	logic        over_q, over_d;
	logic        under_q, under_d;
	logic        stale_q, stale_d;
	logic [15:0] gap_q, gap_d;
	logic        start;
	logic        sleep_req;

	assign sleep_req = pin_q[PIN_SLEEP];

	// Next state, successive approximation and result formation.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sar_d   = sar_q;
		bit_d   = bit_q;
		over_d  = over_q;
		under_d = under_q;
		stale_d = stale_q;
		word_d  = word_q;
		push    = 1'b0;
		start   = 1'b0;
		gap_d   = (gap_q == CODE_MAX) ? gap_q : gap_q + 16'h0001;
		case (state_q)
			ST_ACQ: begin
				if (cnt_q != 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end else if (sleep_req) begin
					state_d = ST_SLEEP; // R17
				end else if (!pin_q[PIN_CNV] && fifo_ready) begin
					start = 1'b1; // R18
				end else begin
					state_d = ST_WAIT; // R18
				end
			end
			ST_WAIT: begin
				if (sleep_req) begin
					state_d = ST_SLEEP; // R17
				end else if (cnv_fall && fifo_ready) begin
					start = 1'b1; // R1
				end
			end
			ST_CONV: begin
				// Keep the trial bit only if the held input reaches it.
				if (!comp_i) begin
					sar_d[bit_q] = 1'b0; // R3
				end
				if (bit_q != 4'h0) begin
					sar_d[bit_q - 4'h1] = 1'b1; // R3
					bit_d = bit_q - 4'h1;
				end else begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				// Clamp, code, and queue the result of this sample.
				if (over_q) begin
					word_d.code = fmt_code(CODE_MAX, pin_q[PIN_CODING]); // R14
				end else if (under_q) begin
					word_d.code = fmt_code(CODE_MIN, pin_q[PIN_CODING]); // R15
				end else begin
					word_d.code = fmt_code(sar_q, pin_q[PIN_CODING]); // R10
				end
				word_d.stale = stale_q; // R5
				push    = 1'b1; // R4
				cnt_d   = acq_count(mode_q);
				state_d = sleep_req ? ST_SLEEP : ST_ACQ; // R17
			end
			ST_SLEEP: begin
				if (!sleep_req) begin
					cnt_d   = acq_count(mode_q);
					state_d = ST_ACQ;
				end
			end
			default: begin
				state_d = ST_ACQ;
			end
		endcase
		// Freeze the sample and its range flags at conversion start.
		if (start) begin
			state_d = ST_CONV; // R1
			sar_d   = TRIAL_MSB; // R3
			bit_d   = TOP_BIT;
			over_d  = over_range_i; // R2
			under_d = under_range_i; // R2
			stale_d = (mode_q == MODE_WARP) && (gap_q >= GAP_CYCLES); // R6
			gap_d   = 16'h0000;
		end
	end

	// State registers; reset aborts any conversion in flight.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin // R16
			state_q <= ST_ACQ;
			cnt_q   <= 4'(ACQ_NORMAL_CYC - 1);
			sar_q   <= CODE_MIN;
			bit_q   <= 4'h0;
			over_q  <= 1'b0;
			under_q <= 1'b0;
			stale_q <= 1'b0;
			word_q  <= '0;
			gap_q   <= CODE_MAX;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			sar_q   <= sar_d;
			bit_q   <= bit_d;
			over_q  <= over_d;
			under_q <= under_d;
			stale_q <= stale_d;
			word_q  <= word_d;
			gap_q   <= gap_d;
		end
	end

	// Analog switch and status decodes of the state register.
	assign track_o      = (state_q == ST_ACQ) || (state_q == ST_WAIT); // R2
	assign hold_o       = (state_q == ST_CONV) || (state_q == ST_DONE); // R2
	assign busy_o       = hold_o; // R4
	assign dac_trial_o  = sar_q;
	assign power_down_o = (state_q == ST_SLEEP); // R17
	assign low_power_o  = (mode_q == MODE_IMPULSE) && (state_q == ST_WAIT); // R9

	////////////////////////////////////////////////////////////////////////
	// Register port and result bus.

	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              res_rd;

	assign res_rd = rd_i && (addr_i == REG_RESULT);
	// Either a result register read or a finished pin read consumes a word.
	assign pop    = res_rd || rd_rise;

	// Mode write and read data, valid only in the cycle after the strobe.
	always_comb begin
		mode_d  = mode_q;
		rdata_d = '0;
		if (wr_i && (addr_i == REG_CTRL)) begin
			mode_d = mode_type'(wdata_i[CTRL_MODE_LSB +: 2]);
		end
		if (rd_i) begin
			case (addr_i)
				REG_CTRL: begin
					rdata_d[CTRL_MODE_LSB +: 2] = mode_q;
				end
				REG_STATUS: begin
					rdata_d[ST_BUSY_BIT]       = busy_o;
					rdata_d[ST_SLEEP_BIT]      = power_down_o;
					rdata_d[ST_VALID_BIT]      = fifo_valid;
					rdata_d[ST_FULL_BIT]       = !fifo_ready;
					rdata_d[ST_LEVEL_LSB +: 5] = fifo_level;
				end
				REG_RESULT: begin
					if (fifo_valid) begin
						rdata_d[15:0]          = head.code;
						rdata_d[RES_STALE_BIT] = head.stale;
					end
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// Mode and read data registers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q  <= mode_type'(CTRL_MODE_RST);
			rdata_q <= '0;
		end else begin
			mode_q  <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o     = rdata_q;
	// The head word sits in the memory's output register.
	assign data_o      = head.code;
	assign data_oe_n_o = pin_q[PIN_CS] || pin_q[PIN_RD]; // R19

endmodule

`default_nettype wire

// ==== sar_pkg.sv ====
// Constants, types and the carrier struct of the SAR conversion control.
// Assumes a single 10 MHz clock and one asynchronous active-high reset.
//
// Overview of operation
// [R1] Falling convert start ends acquisition, begins conversion; the code ignores the fall while the FIFO is full.
// [R2] Track while acquiring, freeze difference at start.
// [R3] Sixteen binary weighted trials, most significant first.
// [R4] Present output code, then drop busy low.
// [R5] Result belongs to its own conversion's sample.
// [R6] Fast mode; accurate only with gaps below 1 ms.
// [R7] Host discards first fast result after long gap.
// [R8] General mode places no limit on conversion gaps.
// [R9] Low-power mode saves power between conversions.
// [R10] Coding select picks binary or twos complement.
// [R11] High selects binary; sampled when code forms.
// [R12] Straight binary step is reference over 65536.
// [R13] Twos complement inverts the top bit.
// [R14] Overrange saturates to the maximum code.
// [R15] Underrange saturates to the minimum code.
// [R16] Reset high aborts conversion and clears control.
// [R17] Sleep finishes current conversion, then blocks more.
// [R18] Start at once if start already low.
// [R19] Drive result bus only while select and read low.
`default_nettype none

package sar_pkg;

	// Clock and widths.
	localparam int CLK_NS     = 100;
	localparam int CODE_W     = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;

	// Field positions.
	localparam int CTRL_MODE_LSB = 0;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_SLEEP_BIT  = 1;
	localparam int ST_VALID_BIT  = 2;
	localparam int ST_FULL_BIT   = 3;
	localparam int ST_LEVEL_LSB  = 8;
	localparam int RES_STALE_BIT = 16;

	// Output code figures.
	localparam logic [15:0] CODE_MAX = 16'hFFFF;
	localparam logic [15:0] CODE_MIN = 16'h0000;
	localparam logic [15:0] TRIAL_MSB = 16'h8000;
	localparam logic [3:0]  TOP_BIT  = 4'hF;

	// Acquisition times per mode and the fast mode gap limit.
	localparam int ACQ_WARP_NS    = 250;
	localparam int ACQ_NORMAL_NS  = 400;
	localparam int ACQ_IMPULSE_NS = 600;
	localparam int WARP_GAP_NS    = 1000000;
	localparam int ACQ_WARP_CYC    = (ACQ_WARP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACQ_NORMAL_CYC  = (ACQ_NORMAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACQ_IMPULSE_CYC = (ACQ_IMPULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WARP_GAP_CYC    = WARP_GAP_NS / CLK_NS;

	// Synchronised pin positions and their reset levels.
	localparam int PIN_CNV    = 0;
	localparam int PIN_CODING = 1;
	localparam int PIN_SLEEP  = 2;
	localparam int PIN_CS     = 3;
	localparam int PIN_RD     = 4;
	localparam int PIN_N      = 5;
	localparam logic [4:0] PIN_RST = 5'h1B;

	// Speed and power modes.
	typedef enum logic [1:0] {
		MODE_WARP    = 2'h0,
		MODE_NORMAL  = 2'h1,
		MODE_IMPULSE = 2'h2
	} mode_type;

	localparam logic [1:0] CTRL_MODE_RST = 2'h1;

	// Converter states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		ST_ACQ   = 3'h0,
		ST_WAIT  = 3'h1,
		ST_CONV  = 3'h3,
		ST_DONE  = 3'h2,
		ST_SLEEP = 3'h6
	} state_type;

	// One finished conversion as it travels through the FIFO.
	typedef struct packed {
		logic        stale;
		logic [15:0] code;
	} result_word_type;

endpackage

`default_nettype wire

// ==== sar_ram.sv ====
// Small dual-port memory with a registered, write-first read port.
// Assumes write and read share one clock.
`default_nettype none

module sar_ram #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdata_d;

	// Write-first so a word written to the read address shows at once.
	always_comb begin
		rdata_d = mem[raddr_i];
		if (we_i && (waddr_i == raddr_i)) begin
			rdata_d = wdata_i;
		end
	end

	// Storage array; it needs no reset.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Registered read data.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// ==== sar_fifo.sv ====
// Show-ahead FIFO with valid and ready on both sides.
// Assumes one clock; storage lives in sar_ram.
`default_nettype none

module sar_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic      [WIDTH-1:0]         out_data_o,
	output logic      [$clog2(DEPTH):0]   level_o
);

	localparam int AW = $clog2(DEPTH);

	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0]   count_q, count_d;
	logic          do_w, do_r;

	// Full and empty come straight from the word count.
	assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
	assign out_valid_o = (count_q != '0);
	assign level_o     = count_q;

	// Pointer and count update.
	always_comb begin
		do_w     = in_valid_i && in_ready_o;
		do_r     = out_ready_i && out_valid_o;
		wr_ptr_d = wr_ptr_q + AW'(do_w);
		rd_ptr_d = rd_ptr_q + AW'(do_r);
		count_d  = count_q + (AW+1)'(do_w) - (AW+1)'(do_r);
	end

	// Pointer registers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	// Reading at the next pointer keeps the head word on the output.
	sar_ram #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.AW   (AW)
	) u_ram (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.we_i   (do_w),
		.waddr_i(wr_ptr_q),
		.wdata_i(in_data_i),
		.raddr_i(rd_ptr_d),
		.rdata_o(out_data_o)
	);

endmodule

`default_nettype wire

// ==== sar_conversion_control_asserts.sv ====
// Concurrent checks on the ports of the SAR conversion control.
// Assumes one clock and the asynchronous active-high reset of the block.
`default_nettype none

module sar_conversion_control_asserts
	import sar_pkg::*;
#(
	parameter logic [15:0] GAP_CYCLES = 16'(WARP_GAP_CYC)
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        convert_start_n_i,
	input wire logic        cs_n_i,
	input wire logic        rd_n_i,
	input wire logic        comp_i,
	input wire logic        track_o,
	input wire logic        hold_o,
	input wire logic        busy_o,
	input wire logic [15:0] dac_trial_o,
	input wire logic        low_power_o,
	input wire logic        power_down_o,
	input wire logic        data_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [4:0] busy_len_q;
	logic [4:0] busy_len_d;

	// Counts the cycles that busy has stood high without a break.
	always_comb begin
		busy_len_d = busy_o ? busy_len_q + 5'h01 : 5'h00;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_len_q <= 5'h00;
		end else begin
			busy_len_q <= busy_len_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Relations between the pins, trial word and the state flags.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_busy_len;
		$fell(busy_o) |-> busy_len_q == 5'h11;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_first;
		$rose(hold_o) |-> dac_trial_o == 16'h8000;
	endproperty
	a_first: assert property (p_first) else $error("first trial");
	property p_second;
		$rose(hold_o) |=> dac_trial_o == {$past(comp_i), 15'h4000};
	endproperty
	a_second: assert property (p_second) else $error("second trial");
	// Busy mirrors hold, and a conversion only starts from tracking.
	property p_busy_hold;
		(busy_o == hold_o) && (!$rose(busy_o) || $past(track_o));
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy");
	property p_track;
		!(track_o && hold_o);
	endproperty
	a_track: assert property (p_track) else $error("track in hold");
	property p_start;
		$rose(busy_o) |-> !($past(convert_start_n_i, 2) &&
			$past(convert_start_n_i, 4) && $past(convert_start_n_i, 6));
	endproperty
	a_start: assert property (p_start) else $error("start cause");
	property p_oe_off;
		cs_n_i [*5] |-> data_oe_n_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven");
	property p_oe_on;
		(!cs_n_i && !rd_n_i) [*6] |-> !data_oe_n_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus idle");
	property p_sleep;
		power_down_o |-> !busy_o && !track_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep state");
	property p_low_power;
		low_power_o |-> track_o && !busy_o;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low power");

	// Main scenarios reached by the bench.
	c_conv: cover property ($rose(busy_o));
	c_sleep: cover property ($rose(power_down_o));
	c_read: cover property (!data_oe_n_o);
endmodule

bind sar_conversion_control sar_conversion_control_asserts #(
	.GAP_CYCLES(GAP_CYCLES)
) u_asserts (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.convert_start_n_i(convert_start_n_i),
	.cs_n_i(cs_n_i),
	.rd_n_i(rd_n_i),
	.comp_i(comp_i),
	.track_o(track_o),
	.hold_o(hold_o),
	.busy_o(busy_o),
	.dac_trial_o(dac_trial_o),
	.low_power_o(low_power_o),
	.power_down_o(power_down_o),
	.data_oe_n_o(data_oe_n_o)
);

`default_nettype wire

// ==== sar_analog_model.sv ====
// Analog front end: tracks the input difference and compares it.
// Assumes the control's track flag and trial word on the same clock.
`default_nettype none

module sar_analog_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        track_i,
	input  wire logic [15:0] vin_i,
	input  wire logic [15:0] dac_i,
	output logic             comp_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [15:0] held_q;

	// Follows the input while tracking and freezes it otherwise.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			held_q <= 16'h0000;
		end else if (track_i) begin
			held_q <= vin_i;
		end
	end

	// High when the held sample reaches the trial level.
	assign comp_o = (held_q >= dac_i);
endmodule

`default_nettype wire

// ==== sar_conversion_control_tb.sv ====
// Self-checking bench of the SAR conversion control.
// Assumes sar_pkg, the design files, the checker and the analog model.
`default_nettype none

module sar_conversion_control_tb
	import sar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk_i;
	logic              rst_i;
	logic              convert_start_n_i;
	logic              coding_select_i;
	logic              sleep_request_i;
	logic              cs_n_i;
	logic              rd_n_i;
	logic              comp_i;
	logic              over_range_i;
	logic              under_range_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic              wr_i;
	logic              rd_i;
	logic [DATA_W-1:0] rdata_o;
	logic              track_o;
	logic              hold_o;
	logic              busy_o;
	logic [15:0]       dac_trial_o;
	logic              low_power_o;
	logic              power_down_o;
	logic [15:0]       data_o;
	logic              data_oe_n_o;
	logic [15:0]       vin;
	logic [DATA_W-1:0] rword;
	int                bad_count;
	int                samples_checked;

	sar_conversion_control #(.GAP_CYCLES(16'h0032)) uut (
		.clk_i(clk_i), .rst_i(rst_i),
		.convert_start_n_i(convert_start_n_i),
		.coding_select_i(coding_select_i),
		.sleep_request_i(sleep_request_i),
		.cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .comp_i(comp_i),
		.over_range_i(over_range_i), .under_range_i(under_range_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .track_o(track_o), .hold_o(hold_o),
		.busy_o(busy_o), .dac_trial_o(dac_trial_o),
		.low_power_o(low_power_o), .power_down_o(power_down_o),
		.data_o(data_o), .data_oe_n_o(data_oe_n_o)
	);

	sar_analog_model u_model (
		.clk_i(clk_i), .rst_i(rst_i), .track_i(track_o),
		.vin_i(vin), .dac_i(dac_trial_o), .comp_o(comp_i)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock of 100 ns period.
	always #(CLK_NS / 2) clk_i = ~clk_i;

	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string msg);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// Waits a bounded time for busy to reach a level.
	task automatic wait_busy(input logic lvl, input int n);
		int k;
		k = 0;
		while (busy_o !== lvl && k < n) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk(32'(busy_o), 32'(lvl), "busy wait");
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			chk(32'(busy_o), 32'h0, "unexpected start");
		end
	endtask

	// Register port: one-cycle strobes, read data the cycle after.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1;
		rword = rdata_o;
	endtask

	task automatic conv(input logic [15:0] v);
		@(posedge clk_i);
		vin <= v;
		convert_start_n_i <= 1'h0;
		wait_busy(1'h1, 20);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		wait_busy(1'h0, 30);
	endtask

	task automatic conv_chk(input logic cs, input logic [15:0] v,
			input logic ov, input logic un, input logic [31:0] exp);
		@(posedge clk_i);
		coding_select_i <= cs;
		over_range_i <= ov;
		under_range_i <= un;
		conv(v);
		rd(REG_RESULT);
		chk(rword, exp, "result word");
	endtask

	// Fills the FIFO, loses a start, reads the head on pins, drains.
	task automatic t_fifo();
		for (int i = 0; i < 16; i++) begin
			conv(16'(16'hFFFF - i * 16'h1111));
		end
		rd(REG_STATUS);
		chk(rword, 32'h0000100C, "full status");
		@(posedge clk_i);
		convert_start_n_i <= 1'h0;
		quiet(30);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		cs_n_i <= 1'h0;
		rd_n_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		#1;
		chk({15'h0, data_oe_n_o, data_o}, 32'h0000FFFF, "pins");
		@(posedge clk_i);
		rd_n_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		cs_n_i <= 1'h1;
		for (int i = 1; i < 16; i++) begin
			rd(REG_RESULT);
			chk(rword, 32'(16'hFFFF - i * 16'h1111), "order");
		end
		rd(REG_RESULT);
		chk(rword, 32'h0, "empty read");
	endtask

	task automatic t_codes();
		conv_chk(1'h1, 16'h8000, 1'h0, 1'h0, 32'h00008000);
		conv_chk(1'h1, 16'h8000, 1'h1, 1'h0, 32'h0000FFFF);
		conv_chk(1'h1, 16'h8000, 1'h0, 1'h1, 32'h00000000);
		conv_chk(1'h0, 16'h0000, 1'h0, 1'h0, 32'h00008000);
		conv_chk(1'h0, 16'h8000, 1'h0, 1'h0, 32'h00000000);
		conv_chk(1'h0, 16'hFFFF, 1'h0, 1'h0, 32'h00007FFF);
		conv_chk(1'h0, 16'h8000, 1'h1, 1'h0, 32'h00007FFF);
		conv_chk(1'h0, 16'h8000, 1'h0, 1'h1, 32'h00008000);
		conv_chk(1'h1, 16'h7FFF, 1'h0, 1'h0, 32'h00007FFF);
	endtask

	// Input moves during a conversion; start held low restarts.
	task automatic t_hold();
		@(posedge clk_i);
		vin <= 16'h1234;
		convert_start_n_i <= 1'h0;
		wait_busy(1'h1, 20);
		@(posedge clk_i);
		vin <= 16'hBEEF;
		wait_busy(1'h0, 30);
		wait_busy(1'h1, 12);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		wait_busy(1'h0, 30);
		rd(REG_RESULT);
		chk(rword, 32'h00001234, "held sample");
		rd(REG_RESULT);
		chk(rword, 32'h0000BEEF, "second sample");
	endtask

	task automatic t_modes();
		wr(REG_CTRL, 32'h0);
		repeat (60) @(posedge clk_i);
		conv_chk(1'h1, 16'h4321, 1'h0, 1'h0, 32'h00014321);
		conv_chk(1'h1, 16'h4321, 1'h0, 1'h0, 32'h00004321);
		wr(REG_CTRL, 32'h1);
		repeat (60) @(posedge clk_i);
		conv_chk(1'h1, 16'h0001, 1'h0, 1'h0, 32'h00000001);
		wr(REG_CTRL, 32'h2);
		rd(REG_CTRL);
		chk(rword, 32'h2, "mode readback");
		conv_chk(1'h1, 16'h0002, 1'h0, 1'h0, 32'h00000002);
		repeat (10) @(posedge clk_i);
		#1;
		chk(32'(low_power_o), 32'h1, "low power");
	endtask

	task automatic t_sleep();
		@(posedge clk_i);
		vin <= 16'h0F0F;
		convert_start_n_i <= 1'h0;
		wait_busy(1'h1, 20);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		sleep_request_i <= 1'h1;
		wait_busy(1'h0, 30);
		rd(REG_RESULT);
		chk(rword, 32'h00000F0F, "finished");
		chk(32'(power_down_o), 32'h1, "asleep");
		@(posedge clk_i);
		convert_start_n_i <= 1'h0;
		quiet(30);
		@(posedge clk_i);
		sleep_request_i <= 1'h0;
		wait_busy(1'h1, 20);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		wait_busy(1'h0, 30);
	endtask

	// Reset in mid-conversion, then register reset values and refusals.
	task automatic t_abort();
		@(posedge clk_i);
		convert_start_n_i <= 1'h0;
		wait_busy(1'h1, 20);
		@(posedge clk_i);
		convert_start_n_i <= 1'h1;
		rst_i <= 1'h1;
		@(posedge clk_i);
		#1;
		chk(32'(busy_o), 32'h0, "abort");
		@(posedge clk_i);
		rst_i <= 1'h0;
		rd(REG_STATUS);
		chk(rword, 32'h0, "status after reset");
		rd(REG_CTRL);
		chk(rword, 32'h1, "mode after reset");
		wr(8'h0C, 32'hFFFFFFFF);
		wr(REG_STATUS, 32'hFFFFFFFF);
		rd(8'h0C);
		chk(rword, 32'h0, "unmapped read");
		rd(REG_STATUS);
		chk(rword, 32'h0, "status write ignored");
		// The spare mode code reads back and converts like normal mode.
		wr(REG_CTRL, 32'h3);
		rd(REG_CTRL);
		chk(rword, 32'h3, "spare mode readback");
		conv_chk(1'h1, 16'h0003, 1'h0, 1'h0, 32'h00000003);
	endtask

	initial begin
		clk_i = 1'h0;
		rst_i = 1'h1;
		convert_start_n_i = 1'h1;
		coding_select_i = 1'h1;
		sleep_request_i = 1'h0;
		cs_n_i = 1'h1;
		rd_n_i = 1'h1;
		over_range_i = 1'h0;
		under_range_i = 1'h0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'h0;
		rd_i = 1'h0;
		vin = 16'h0000;
		bad_count = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		t_fifo();
		t_codes();
		t_hold();
		t_modes();
		t_sleep();
		t_abort();
		finish_test();
	end

	// Watchdog: the scenarios need about 1100 cycles.
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		finish_test();
	end
endmodule

`default_nettype wire
